// ==== design/psr_pkg.sv ====
// Shared constants and types for the satellite sensor receiver.
package psr_pkg;
	// ----------------------------------------
	// Structure
	// ----------------------------------------
	localparam int NCH = 4;
	localparam int NSLOT = 3;
	localparam int DW = 10;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int SYNC_SHORT_NS = 3000;
	localparam int SYNC_LONG_NS = 6000;
	localparam logic [8:0] SYNC_SHORT_CYC = 9'((SYNC_SHORT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [8:0] SYNC_LONG_CYC = 9'((SYNC_LONG_NS * CLK_MHZ + 999) / 1000);
	localparam logic [8:0] SYNC_CNT_RST = 9'h000;
	// ----------------------------------------
	// Manchester decoding, eight time-base ticks per bit
	// ----------------------------------------
	localparam logic [2:0] PH_FIRST_HALF = 3'h6;
	localparam logic [2:0] PH_SECOND_HALF = 3'h2;
	localparam logic [3:0] FRAME_BITS = 4'hC;
	localparam logic [1:0] LAST_SLOT = 2'h2;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [DW-1:0] DATA_RST = 10'h000;
	// ----------------------------------------
	// Converter sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		PSR_ADC_IDLE = 2'h0,
		PSR_ADC_ANA = 2'h1,
		PSR_ADC_DIAG = 2'h2
	} psr_adc_e;
endpackage

// ==== design/psr_channel.sv ====
// One satellite channel: sync-armed Manchester frame decoder with three slot registers.
`timescale 1ns/1ps
module psr_channel (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Control
	input wire logic tick,
	input wire logic enable,
	input wire logic steered,
	input wire logic sync_start,
	// Line
	input wire logic cur_sense,
	// Results
	output logic [psr_pkg::NSLOT-1:0][psr_pkg::DW-1:0] msg,
	output logic frame_done,
	output logic frame_err,
	output logic [1:0] frame_slot
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic cur_q;
		logic armed;
		logic busy;
		logic [2:0] phase;
		logic have_a;
		logic a;
		logic bad;
		logic [3:0] bitcnt;
		logic [10:0] shreg;
		logic [1:0] slot;
		logic [psr_pkg::NSLOT-1:0][psr_pkg::DW-1:0] msg;
		logic done;
		logic err;
		logic [1:0] dslot;
	} psr_chan_s;

	psr_chan_s s;
	psr_chan_s next_s;

	// ----------------------------------------
	// Decoder
	// ----------------------------------------
	always_comb begin
		logic [10:0] sh;
		logic e;
		logic [1:0] idx;
		sh = {s.a, s.shreg[10:1]};
		e = s.bad | (s.a == cur_sense) | (^sh);
		idx = steered ? 2'h0 : s.slot;
		next_s = s;
		next_s.cur_q = cur_sense;
		next_s.done = 1'b0;
		next_s.err = 1'b0;
		if (sync_start) begin
			// Only a sync request opens the receive window.
			next_s.armed = enable;
			next_s.slot = 2'h0;
			next_s.busy = 1'b0;
		end else if (!enable) begin
			next_s.armed = 1'b0;
			next_s.busy = 1'b0;
		end else if (!s.busy) begin
			// A rising current edge while armed is the mid-bit of the first start bit.
			if (s.armed && cur_sense && !s.cur_q) begin
				next_s.busy = 1'b1;
				next_s.phase = 3'h0;
				next_s.have_a = 1'b0;
				next_s.bad = 1'b0;
				next_s.bitcnt = 4'h0;
			end
		end else if (tick) begin
			// The external time base paces the half-bit samples.
			next_s.phase = s.phase + 3'h1;
			if (s.phase == psr_pkg::PH_FIRST_HALF) begin
				next_s.a = cur_sense;
				next_s.have_a = 1'b1;
			end else if (s.phase == psr_pkg::PH_SECOND_HALF && s.have_a) begin
				next_s.have_a = 1'b0;
				next_s.bitcnt = s.bitcnt + 4'h1;
				if (s.a == cur_sense) begin
					next_s.bad = 1'b1;
				end
				if (s.bitcnt == 4'h0) begin
					next_s.bad = s.bad | s.a | (s.a == cur_sense);
				end else begin
					next_s.shreg = sh;
				end
				if (s.bitcnt == psr_pkg::FRAME_BITS - 4'h1) begin
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
					next_s.err = e;
					next_s.dslot = idx;
					// The slot register changes only once the whole frame checked out.
					if (!e) begin
						next_s.msg[idx] = sh[9:0];
					end
					// Three sensors answer per sync, or one when steered.
					next_s.slot = s.slot + 2'h1;
					if (steered || s.slot == psr_pkg::LAST_SLOT) begin
						next_s.armed = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign msg = s.msg;
	assign frame_done = s.done;
	assign frame_err = s.err;
	assign frame_slot = s.dslot;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_msg_whole: assert property (@(posedge mclk) disable iff (!resetn)
		!$stable(s.msg) |-> s.done && !s.err)
		else $error("slot register changed without a complete good frame");
	chk_async_drop: assert property (@(posedge mclk) disable iff (!resetn)
		!s.armed && !s.busy && !sync_start |=> !s.busy)
		else $error("frame started without a sync request");
	chk_disabled_hold: assert property (@(posedge mclk) disable iff (!resetn)
		!enable |=> $stable(s.msg))
		else $error("disabled channel changed its messages");
endmodule

// ==== design/psr_top.sv ====
// Four-channel satellite receiver with sync generation, safing converter path and line pass-through.
//
// Contract
// - Four channels, each enabled or disabled on its own.
// - Up to twelve sensors in all, three per channel.
// - Channels run synchronous parallel mode with three time slots.
// - A steered synchronous mode with 10-bit payloads is also offered.
// - Only frames following a sync request are received.
// - Bidirectional traffic is sequenced by software; hardware offers long sync pulses.
// - Mode selection and status reading happen through the control ports.
// - Each sync request that arrives with the sync pulse timer idle makes a sync pulse on every enabled channel.
// - The external clock input is the Manchester sampling time base.
// - Sensor bits are recovered from current modulation as Manchester code.
// - Three readable message registers per channel hold the latest messages.
// - A fault on one channel leaves the other channels undisturbed.
// - Each sync request that finds the shared converter idle starts a safing-sensor conversion on it.
// - Each safing-sensor conversion result taken without self-test inhibit lands in a readable 10-bit analog data register.
// - Self-test inhibit freezes the analog data register.
// - The serial line output can carry raw code of any one channel.
`timescale 1ns/1ps
module psr_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Requests from the controller
	input wire logic sync_req,
	input wire logic dec_clk,
	// Channel configuration
	input wire logic [psr_pkg::NCH-1:0] chan_enable,
	input wire logic [psr_pkg::NCH-1:0] chan_steered,
	input wire logic [psr_pkg::NCH-1:0] sync_long,
	// Satellite links
	input wire logic [psr_pkg::NCH-1:0] cur_sense,
	output logic [psr_pkg::NCH-1:0] sync_pulse,
	// Status
	input wire logic [psr_pkg::NCH-1:0] status_clr,
	output logic [psr_pkg::NCH-1:0] chan_err,
	output logic [psr_pkg::NCH*psr_pkg::NSLOT-1:0] slot_fresh,
	// Message read
	input wire logic [1:0] rd_chan,
	input wire logic [1:0] rd_slot,
	output logic [psr_pkg::DW-1:0] rd_data,
	// Shared converter
	output logic adc_start,
	output logic adc_use_diag,
	input wire logic adc_done,
	input wire logic [psr_pkg::DW-1:0] adc_result,
	input wire logic diag_req,
	input wire logic analog_selftest_inhibit,
	output logic [psr_pkg::DW-1:0] analog_data,
	output logic [psr_pkg::DW-1:0] diag_data,
	// Serial line
	input wire logic [2:0] line_sel,
	input wire logic line_tx_in,
	output logic line_out
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic sync_q;
		logic dec_q;
		logic sync_active;
		logic [8:0] sync_cnt;
		logic [psr_pkg::NCH-1:0] sync_en;
		logic [psr_pkg::NCH-1:0] sync_lg;
		logic [psr_pkg::NCH-1:0] err;
		logic [psr_pkg::NCH*psr_pkg::NSLOT-1:0] fresh;
		logic [psr_pkg::DW-1:0] rd;
		psr_pkg::psr_adc_e adc;
		logic start;
		logic diag_pend;
		logic [psr_pkg::DW-1:0] ana;
		logic [psr_pkg::DW-1:0] diag;
		logic line;
	} psr_top_s;

	psr_top_s s;
	psr_top_s next_s;

	logic sync_rise;
	logic tick;
	logic [psr_pkg::NCH-1:0] sync_start;
	logic [psr_pkg::NCH-1:0] f_done;
	logic [psr_pkg::NCH-1:0] f_err;
	logic [psr_pkg::NCH-1:0][1:0] f_slot;
	logic [psr_pkg::NCH-1:0][psr_pkg::NSLOT-1:0][psr_pkg::DW-1:0] msg;

	assign sync_rise = sync_req && !s.sync_q;
	assign tick = dec_clk && !s.dec_q;
	assign sync_start = sync_rise ? chan_enable : '0;

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	// Each channel is its own instance, so a fault stays on its channel.
	for (genvar c = 0; c < psr_pkg::NCH; c++) begin : g_ch
		psr_channel u_ch (
			.mclk(mclk),
			.resetn(resetn),
			.tick(tick),
			.enable(chan_enable[c]),
			.steered(chan_steered[c]),
			.sync_start(sync_start[c]),
			.cur_sense(cur_sense[c]),
			.msg(msg[c]),
			.frame_done(f_done[c]),
			.frame_err(f_err[c]),
			.frame_slot(f_slot[c])
		);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [3:0] fi;
		fi = 4'h0;
		next_s = s;
		next_s.sync_q = sync_req;
		next_s.dec_q = dec_clk;
		next_s.start = 1'b0;
		// Sync pulse timer; enables and lengths are caught at the request.
		if (sync_rise && !s.sync_active) begin
			next_s.sync_active = 1'b1;
			next_s.sync_cnt = psr_pkg::SYNC_CNT_RST;
			next_s.sync_en = chan_enable;
			next_s.sync_lg = sync_long;
		end else if (s.sync_active) begin
			next_s.sync_cnt = s.sync_cnt + 9'h001;
			if (s.sync_cnt == psr_pkg::SYNC_LONG_CYC - 9'h001) begin
				next_s.sync_active = 1'b0;
			end
		end
		// Status flags: a new event wins over a clear in the same cycle.
		for (int c = 0; c < psr_pkg::NCH; c++) begin
			if (status_clr[c]) begin
				next_s.err[c] = 1'b0;
				for (int k = 0; k < psr_pkg::NSLOT; k++) begin
					next_s.fresh[c * psr_pkg::NSLOT + k] = 1'b0;
				end
			end
			if (f_done[c] && f_err[c]) begin
				next_s.err[c] = 1'b1;
			end
			if (f_done[c] && !f_err[c]) begin
				fi = 4'(c * psr_pkg::NSLOT) + 4'(f_slot[c]);
				next_s.fresh[fi] = 1'b1;
			end
		end
		// Message read port.
		if (rd_slot == psr_pkg::LAST_SLOT + 2'h1) begin
			next_s.rd = psr_pkg::DATA_RST;
		end else begin
			next_s.rd = msg[rd_chan][rd_slot];
		end
		// Shared converter: sync-triggered sensor conversion has priority.
		if (diag_req) begin
			next_s.diag_pend = 1'b1;
		end
		unique case (s.adc)
			psr_pkg::PSR_ADC_IDLE: begin
				if (sync_rise) begin
					next_s.adc = psr_pkg::PSR_ADC_ANA;
					next_s.start = 1'b1;
				end else if (s.diag_pend) begin
					next_s.adc = psr_pkg::PSR_ADC_DIAG;
					next_s.start = 1'b1;
					next_s.diag_pend = 1'b0;
				end
			end
			psr_pkg::PSR_ADC_ANA: begin
				if (adc_done) begin
					next_s.adc = psr_pkg::PSR_ADC_IDLE;
					// Self-test inhibit keeps the buffer frozen.
					if (!analog_selftest_inhibit) begin
						next_s.ana = adc_result;
					end
				end
			end
			psr_pkg::PSR_ADC_DIAG: begin
				if (adc_done) begin
					next_s.adc = psr_pkg::PSR_ADC_IDLE;
					next_s.diag = adc_result;
				end
			end
			default: begin
				next_s.adc = psr_pkg::PSR_ADC_IDLE;
			end
		endcase
		// Raw code pass-through onto the serial line.
		if (line_sel[2]) begin
			next_s.line = cur_sense[line_sel[1:0]];
		end else begin
			next_s.line = line_tx_in;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		for (int c = 0; c < psr_pkg::NCH; c++) begin
			sync_pulse[c] = s.sync_active && s.sync_en[c] &&
				(s.sync_lg[c] || s.sync_cnt < psr_pkg::SYNC_SHORT_CYC);
		end
	end

	assign chan_err = s.err;
	assign slot_fresh = s.fresh;
	assign rd_data = s.rd;
	assign adc_start = s.start;
	assign adc_use_diag = (s.adc == psr_pkg::PSR_ADC_DIAG);
	assign analog_data = s.ana;
	assign diag_data = s.diag;
	assign line_out = s.line;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seq_sync_new;
		sync_req && !s.sync_q && !s.sync_active;
	endsequence

	sequence seq_short_end;
		$fell(sync_pulse[0]) && !s.sync_lg[0];
	endsequence

	chk_sync_emit: assert property (@(posedge mclk) disable iff (!resetn)
		seq_sync_new ##0 chan_enable[0] |=> sync_pulse[0] [*4])
		else $error("enabled channel gave no sync pulse");
	chk_sync_quiet: assert property (@(posedge mclk) disable iff (!resetn)
		seq_sync_new ##0 !chan_enable[0] |=> !sync_pulse[0] [*8])
		else $error("disabled channel gave a sync pulse");
	chk_sync_width: assert property (@(posedge mclk) disable iff (!resetn)
		seq_short_end |-> s.sync_cnt == psr_pkg::SYNC_SHORT_CYC)
		else $error("short sync pulse has the wrong width");
	chk_adc_trigger: assert property (@(posedge mclk) disable iff (!resetn)
		sync_rise && s.adc == psr_pkg::PSR_ADC_IDLE |=> adc_start && !adc_use_diag)
		else $error("sync request did not start a sensor conversion");
	chk_ana_store: assert property (@(posedge mclk) disable iff (!resetn)
		s.adc == psr_pkg::PSR_ADC_ANA && adc_done && !analog_selftest_inhibit
		|=> analog_data == $past(adc_result))
		else $error("conversion result not stored");
	chk_ana_freeze: assert property (@(posedge mclk) disable iff (!resetn)
		analog_selftest_inhibit |=> $stable(analog_data))
		else $error("analog buffer updated during self-test inhibit");
	chk_line_pass: assert property (@(posedge mclk) disable iff (!resetn)
		line_sel[2] |=> line_out == $past(cur_sense[line_sel[1:0]]))
		else $error("serial line does not carry the selected channel");
	chk_err_sticky: assert property (@(posedge mclk) disable iff (!resetn)
		f_done[1] && f_err[1] ##1 !status_clr[1] [*2] |-> chan_err[1])
		else $error("frame error flag lost");
	chk_rd_path: assert property (@(posedge mclk) disable iff (!resetn)
		rd_slot != 2'h3 |=> rd_data == $past(msg[rd_chan][rd_slot]))
		else $error("read port does not show the addressed message");
	chk_diag_start: assert property (@(posedge mclk) disable iff (!resetn)
		s.adc == psr_pkg::PSR_ADC_IDLE && !sync_rise && s.diag_pend |=> adc_start && adc_use_diag)
		else $error("pending diagnostic conversion did not start");
	chk_diag_store: assert property (@(posedge mclk) disable iff (!resetn)
		s.adc == psr_pkg::PSR_ADC_DIAG && adc_done |=> diag_data == $past(adc_result))
		else $error("diagnostic result not stored");
	chk_start_once: assert property (@(posedge mclk) disable iff (!resetn)
		adc_start |=> !adc_start)
		else $error("converter start stood longer than one cycle");
	chk_line_tx: assert property (@(posedge mclk) disable iff (!resetn)
		!line_sel[2] |=> line_out == $past(line_tx_in))
		else $error("serial line does not carry the transmit input");

	// ----------------------------------------
	// Per-channel checks
	// ----------------------------------------
	for (genvar c = 0; c < psr_pkg::NCH; c++) begin : g_chk
		sequence seq_req_on;
			sync_req && !s.sync_q && !s.sync_active && chan_enable[c];
		endsequence

		sequence seq_req_off;
			sync_req && !s.sync_q && !s.sync_active && !chan_enable[c];
		endsequence

		sequence seq_long_end;
			$fell(sync_pulse[c]) && s.sync_lg[c];
		endsequence

		sequence seq_bad_frame;
			f_done[c] && f_err[c];
		endsequence

		chk_pulse_start: assert property (@(posedge mclk) disable iff (!resetn)
			seq_req_on |=> sync_pulse[c] [*8])
			else $error("enabled channel gave no sync pulse");
		chk_pulse_none: assert property (@(posedge mclk) disable iff (!resetn)
			seq_req_off |=> !sync_pulse[c] [*8])
			else $error("disabled channel gave a sync pulse");
		chk_long_width: assert property (@(posedge mclk) disable iff (!resetn)
			seq_long_end |-> s.sync_cnt == psr_pkg::SYNC_LONG_CYC)
			else $error("long sync pulse has the wrong width");
		chk_err_set: assert property (@(posedge mclk) disable iff (!resetn)
			seq_bad_frame |=> chan_err[c])
			else $error("frame error not flagged");
		chk_err_clear: assert property (@(posedge mclk) disable iff (!resetn)
			status_clr[c] && !f_done[c] |=> !chan_err[c])
			else $error("error flag survived its clear");
		chk_err_keep: assert property (@(posedge mclk) disable iff (!resetn)
			chan_err[c] && !status_clr[c] |=> chan_err[c])
			else $error("error flag dropped without a clear");
		chk_done_off: assert property (@(posedge mclk) disable iff (!resetn)
			!chan_enable[c] |=> !f_done[c])
			else $error("disabled channel finished a frame");
		chk_line_each: assert property (@(posedge mclk) disable iff (!resetn)
			line_sel == 3'h4 + 3'(c) |=> line_out == $past(cur_sense[c]))
			else $error("serial line does not carry its channel");

		for (genvar k = 0; k < psr_pkg::NSLOT; k++) begin : g_slot
			sequence seq_good_slot;
				f_done[c] && !f_err[c] && f_slot[c] == 2'(k);
			endsequence

			chk_fresh_set: assert property (@(posedge mclk) disable iff (!resetn)
				seq_good_slot |=> slot_fresh[c * psr_pkg::NSLOT + k])
				else $error("good frame did not mark its slot");
			chk_fresh_clear: assert property (@(posedge mclk) disable iff (!resetn)
				status_clr[c] && !f_done[c] |=> !slot_fresh[c * psr_pkg::NSLOT + k])
				else $error("fresh flag survived its clear");
			chk_fresh_keep: assert property (@(posedge mclk) disable iff (!resetn)
				slot_fresh[c * psr_pkg::NSLOT + k] && !status_clr[c] |=> slot_fresh[c * psr_pkg::NSLOT + k])
				else $error("fresh flag dropped without a clear");
			chk_msg_keep: assert property (@(posedge mclk) disable iff (!resetn)
				!$stable(msg[c][k]) |-> seq_good_slot)
				else $error("message changed without a good frame for its slot");
			chk_rd_each: assert property (@(posedge mclk) disable iff (!resetn)
				rd_chan == 2'(c) && rd_slot == 2'(k) |=> rd_data == $past(msg[c][k]))
				else $error("read port does not show the addressed message");
		end
	end
endmodule

// ==== tb/psr_sat_model.sv ====
// Behavioural model of the remote satellite sensors on the four links.
`timescale 1ns/1ps
module psr_sat_model (
	// Clock
	input wire logic mclk,
	// Links
	output logic [psr_pkg::NCH-1:0] cur_sense
);
	initial cur_sense = 4'h0;
	// Holds one line at a fixed current level.
	task automatic hold(input int ch, input logic v);
		cur_sense[ch] = v;
	endtask
	// Sends two start bits, ten data bits from the lowest and even parity, high-then-low for a one.
	task automatic frame(input int ch, input logic [psr_pkg::DW-1:0] d, input logic bad);
		logic [12:0] b;
		b = {^d ^ bad, d, 2'b00};
		for (int k = 0; k < 13; k++) begin
			repeat (8) @(posedge mclk);
			#1 cur_sense[ch] = b[k];
			repeat (8) @(posedge mclk);
			#1 cur_sense[ch] = ~b[k];
		end
		repeat (8) @(posedge mclk);
		#1 cur_sense[ch] = 1'b0;
	endtask
endmodule

// ==== tb/psr_top_tb.sv ====
// Self-checking bench for the four-channel satellite receiver.
`timescale 1ns/1ps
module psr_top_tb;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic sync_req = 1'b0;
	logic dec_clk = 1'b0;
	logic [3:0] chan_enable = 4'h0;
	logic [3:0] chan_steered = 4'h0;
	logic [3:0] sync_long = 4'h0;
	logic [3:0] cur_sense;
	logic [3:0] sync_pulse;
	logic [3:0] status_clr = 4'h0;
	logic [3:0] chan_err;
	logic [11:0] slot_fresh;
	logic [1:0] rd_chan = 2'h0;
	logic [1:0] rd_slot = 2'h0;
	logic [9:0] rd_data;
	logic adc_start;
	logic adc_use_diag;
	logic adc_done = 1'b0;
	logic [9:0] adc_result = 10'h000;
	logic diag_req = 1'b0;
	logic analog_selftest_inhibit = 1'b0;
	logic [9:0] analog_data;
	logic [9:0] diag_data;
	logic [2:0] line_sel = 3'h0;
	logic line_tx_in = 1'b0;
	logic line_out;
	logic [9:0] conv_val = 10'h000;
	int pw[4];
	int nst;
	int errors = 0;
	int checks_done = 0;

	psr_top dut (.mclk(mclk), .resetn(resetn), .sync_req(sync_req), .dec_clk(dec_clk),
		.chan_enable(chan_enable), .chan_steered(chan_steered), .sync_long(sync_long),
		.cur_sense(cur_sense), .sync_pulse(sync_pulse), .status_clr(status_clr),
		.chan_err(chan_err), .slot_fresh(slot_fresh), .rd_chan(rd_chan), .rd_slot(rd_slot),
		.rd_data(rd_data), .adc_start(adc_start), .adc_use_diag(adc_use_diag),
		.adc_done(adc_done), .adc_result(adc_result), .diag_req(diag_req),
		.analog_selftest_inhibit(analog_selftest_inhibit), .analog_data(analog_data),
		.diag_data(diag_data), .line_sel(line_sel), .line_tx_in(line_tx_in), .line_out(line_out));
	psr_sat_model sat (.mclk(mclk), .cur_sense(cur_sense));

	initial begin
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) dec_clk <= ~dec_clk;

	// Converter answers four cycles after each start, then lets the result bus wander.
	always @(posedge mclk) begin
		if (adc_start === 1'b1) begin
			repeat (4) @(posedge mclk);
			#1 adc_done = 1'b1;
			adc_result = conv_val;
			@(posedge mclk);
			#1 adc_done = 1'b0;
			adc_result = ~conv_val;
		end
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic rd(input int c, input int s, input logic [9:0] e);
		step(1);
		rd_chan = 2'(c);
		rd_slot = 2'(s);
		step(2);
		chk(16'(rd_data), 16'(e));
	endtask

	// Raises a request and counts pulse cycles per channel and converter starts.
	task automatic sync();
		pw = '{0, 0, 0, 0};
		nst = 0;
		step(1);
		sync_req = 1'b1;
		repeat (320) begin
			step(1);
			nst += int'(adc_start);
			for (int c = 0; c < 4; c++) pw[c] += int'(sync_pulse[c]);
		end
		sync_req = 1'b0;
	endtask

	initial begin
		#1ms;
		errors++;
		final_report();
	end

	initial begin
		step(2);
		resetn = 1'b1;
		step(1);
		chk(16'({chan_err, sync_pulse}), 16'h0000);
		chk(16'(analog_data), 16'h0000);
		chan_enable = 4'hF;
		sat.frame(1, 10'h155, 1'b0);
		chk(16'(slot_fresh), 16'h0000);
		$display("test no_sync done");
		// ----------------------------------------
		// Sync pulses and converter start
		// ----------------------------------------
		chan_enable = 4'h5;
		sync_long = 4'h4;
		conv_val = 10'h2A5;
		sync();
		chk(16'(pw[0]), 16'h0096);
		chk(16'(pw[2]), 16'h012C);
		chk(16'(pw[1] + pw[3]), 16'h0000);
		chk(16'(nst), 16'h0001);
		chk(16'(analog_data), 16'h02A5);
		$display("test sync done");
		chan_enable = 4'hF;
		sync_long = 4'h0;
		sync();
		sat.frame(0, 10'h3A1, 1'b0);
		fork
			sat.frame(0, 10'h05C, 1'b0);
			begin
				step(100);
				rd(0, 1, 10'h000);
			end
		join
		sat.frame(0, 10'h2E7, 1'b0);
		sat.frame(0, 10'h111, 1'b0);
		rd(0, 0, 10'h3A1);
		rd(0, 1, 10'h05C);
		rd(0, 2, 10'h2E7);
		rd(0, 3, 10'h000);
		chk(16'(slot_fresh[2:0]), 16'h0007);
		$display("test frames done");
		chan_steered = 4'h8;
		sync();
		sat.frame(3, 10'h0F0, 1'b0);
		sat.frame(3, 10'h30F, 1'b0);
		rd(3, 0, 10'h0F0);
		rd(3, 1, 10'h000);
		$display("test steered done");
		chan_steered = 4'h0;
		chan_enable = 4'hE;
		status_clr = 4'hF;
		step(1);
		status_clr = 4'h0;
		sync();
		sat.frame(0, 10'h222, 1'b0);
		sat.frame(1, 10'h1FF, 1'b1);
		sat.frame(2, 10'h0AA, 1'b0);
		chk(16'(pw[0]), 16'h0000);
		chk(16'(chan_err), 16'h0002);
		chk(16'(slot_fresh), 16'h0040);
		rd(0, 0, 10'h3A1);
		rd(2, 0, 10'h0AA);
		$display("test isolation done");
		analog_selftest_inhibit = 1'b1;
		conv_val = 10'h1C3;
		sync();
		chk(16'(analog_data), 16'h02A5);
		analog_selftest_inhibit = 1'b0;
		diag_req = 1'b1;
		step(1);
		diag_req = 1'b0;
		step(1);
		chk(16'(adc_use_diag), 16'h0001);
		step(19);
		chk(16'(diag_data), 16'h01C3);
		$display("test converter done");
		chan_enable = 4'h0;
		for (int c = 0; c < 4; c++) begin
			sat.hold(c, 1'b1);
			line_sel = 3'(4 + c);
			step(3);
			chk(16'(line_out), 16'h0001);
			line_sel = 3'(4 + (c + 1) % 4);
			step(3);
			chk(16'(line_out), 16'h0000);
			sat.hold(c, 1'b0);
		end
		line_sel = 3'h0;
		line_tx_in = 1'b1;
		step(3);
		chk(16'(line_out), 16'h0001);
		$display("test line done");
		final_report();
	end
endmodule
